//--- core/ccp_pkg.sv
// Package for the capture/compare/PWM unit: register map, field layout, resets, modes.
// Assumes a 32-bit classic Wishbone slave with one register per aligned word.
package ccp_pkg;

   // ------------------------------------------------------------------
   // Register map (byte addresses)
   // ------------------------------------------------------------------
   localparam logic [7:0] CCP_ADDR_CONTROL = 8'h00;
   localparam logic [7:0] CCP_ADDR_DUTY_LOW = 8'h04;
   localparam logic [7:0] CCP_ADDR_DUTY_HIGH = 8'h08;
   localparam logic [7:0] CCP_ADDR_PERIOD = 8'h0C;
   localparam logic [7:0] CCP_ADDR_CAPTURE_STATUS = 8'h10;

   // ------------------------------------------------------------------
   // Control register fields
   // ------------------------------------------------------------------
   localparam int CCP_CTL_ENABLE_BIT = 7;
   localparam int CCP_CTL_OUT_BIT = 5;
   localparam int CCP_CTL_ALIGN_BIT = 4;
   localparam int CCP_CTL_MODE_LSB = 0;
   localparam logic [7:0] CCP_CTL_WRITE_MASK = 8'h9F;

   // ------------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------------
   localparam logic [7:0] CCP_CONTROL_RESET = 8'h00;
   localparam logic [7:0] CCP_DUTY_RESET = 8'h00;
   localparam logic [7:0] CCP_PERIOD_RESET = 8'hFF;
   localparam logic [9:0] CCP_LATCH_RESET = 10'h000;

   // ------------------------------------------------------------------
   // Mode codes
   // ------------------------------------------------------------------
   localparam logic [3:0] CCP_MODE_OFF = 4'h0;
   localparam logic [3:0] CCP_MODE_CMP_TOGGLE_CLR = 4'h1;
   localparam logic [3:0] CCP_MODE_CMP_TOGGLE = 4'h2;
   localparam logic [3:0] CCP_MODE_CAP_ANY = 4'h3;
   localparam logic [3:0] CCP_MODE_CAP_FALL = 4'h4;
   localparam logic [3:0] CCP_MODE_CAP_RISE = 4'h5;
   localparam logic [3:0] CCP_MODE_CAP_RISE4 = 4'h6;
   localparam logic [3:0] CCP_MODE_CAP_RISE16 = 4'h7;
   localparam logic [3:0] CCP_MODE_CMP_SET = 4'h8;
   localparam logic [3:0] CCP_MODE_CMP_CLEAR = 4'h9;
   localparam logic [3:0] CCP_MODE_CMP_PULSE = 4'hA;
   localparam logic [3:0] CCP_MODE_CMP_PULSE_CLR = 4'hB;
   localparam logic [1:0] CCP_MODE_PWM_TOP = 2'h3;

   // Prescaler count at the last edge of each capture for the prescaled capture modes
   localparam logic [3:0] CCP_CAP_DIV4_LAST = 4'h3;
   localparam logic [3:0] CCP_CAP_DIV16_LAST = 4'hF;

   // Fanout of the unit output toward the other on-chip peripherals
   typedef struct packed {
      logic waveform_generator;
      logic adc_trigger;
      logic timer_reset;
      logic signal_measurement_timer;
      logic configurable_logic_cell;
      logic pin_mapping_unit;
   } ccp_fanout_t;

endpackage

//--- core/ccp_edge_div.sv
// Edge detector and capture prescaler for one synchronised capture input.
// Assumes the input is already synchronised to clk_i by the caller.
module ccp_edge_div (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic clear_i,
   input wire logic sig_i,
   input wire logic [3:0] mode_i,
   output logic event_o
);

   logic prev_q;
   logic [3:0] count_q;
   logic rise;
   logic fall;
   logic edge_hit;

   assign rise = sig_i & ~prev_q;
   assign fall = ~sig_i & prev_q;

   always_comb begin
      unique case (mode_i)
         ccp_pkg::CCP_MODE_CAP_ANY: edge_hit = rise | fall;
         ccp_pkg::CCP_MODE_CAP_FALL: edge_hit = fall;
         ccp_pkg::CCP_MODE_CAP_RISE,
         ccp_pkg::CCP_MODE_CAP_RISE4,
         ccp_pkg::CCP_MODE_CAP_RISE16: edge_hit = rise;
         default: edge_hit = 1'b0;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= sig_i;
      end
   end

   // Prescaler counts qualifying edges and fires on the last one
   always_ff @(posedge clk_i) begin
      if (rst_i || clear_i) begin
         count_q <= 4'h0;
         event_o <= 1'b0;
      end else begin
         event_o <= 1'b0;
         if (edge_hit) begin
            if (mode_i == ccp_pkg::CCP_MODE_CAP_RISE16) begin
               event_o <= (count_q == ccp_pkg::CCP_CAP_DIV16_LAST);
               count_q <= count_q + 4'h1;
            end else if (mode_i == ccp_pkg::CCP_MODE_CAP_RISE4) begin
               event_o <= (count_q == ccp_pkg::CCP_CAP_DIV4_LAST);
               count_q <= (count_q == ccp_pkg::CCP_CAP_DIV4_LAST) ? 4'h0 : count_q + 4'h1;
            end else begin
               event_o <= 1'b1;
            end
         end
      end
   end

endmodule

//--- core/ccp_pwm_mode_control.sv
// Capture/compare/PWM unit with control, duty and period registers on classic Wishbone.
// Assumes the shared 8-bit time base, its prescale phase and the compare timer come in
// as same-clock logic; the capture input is a pin and is synchronised here.
module ccp_pwm_mode_control #(
   parameter int DUTY_WIDTH = 10
) (
   input wire logic clk_i,
   input wire logic rst_i,
   // Classic Wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Shared time base: timer count, increment strobe, 2-bit phase below it
   input wire logic [7:0] timer_count_i,
   input wire logic timer_tick_i,
   input wire logic [1:0] timer_phase_i,
   // Compare/capture timer
   input wire logic [15:0] compare_timer_i,
   input wire logic capture_pin_i,
   output logic timer_clear_o,
   output logic compare_match_o,
   output logic capture_event_o,
   output logic [15:0] capture_value_o,
   // Unit output and its fanout
   output logic unit_out_o,
   output logic pin_oe_o,
   output ccp_pkg::ccp_fanout_t fanout_o
);

   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------
   logic [7:0] control_q;
   logic [7:0] duty_low_q;
   logic [7:0] duty_high_q;
   logic [7:0] period_q;
   logic out_q;
   logic [DUTY_WIDTH-1:0] duty_latch_q;
   logic [15:0] capture_q;
   logic capture_seen_q;
   logic ack_q;
   logic [31:0] rdata_q;
   logic cap_sync1_q;
   logic cap_sync2_q;
   logic match_q;
   logic cap_event;

   logic enable;
   logic align;
   logic [3:0] mode;
   logic pwm_mode;
   logic capture_mode;
   logic [DUTY_WIDTH-1:0] duty_buffer;
   logic [DUTY_WIDTH-1:0] time_base;
   logic wr_stb;
   logic rd_stb;
   logic cmp_hit;
   logic period_end;

   assign enable = control_q[ccp_pkg::CCP_CTL_ENABLE_BIT];
   assign align = control_q[ccp_pkg::CCP_CTL_ALIGN_BIT];
   assign mode = control_q[ccp_pkg::CCP_CTL_MODE_LSB +: 4];
   assign pwm_mode = (mode[3:2] == ccp_pkg::CCP_MODE_PWM_TOP);
   assign capture_mode = (mode >= ccp_pkg::CCP_MODE_CAP_ANY) && (mode <= ccp_pkg::CCP_MODE_CAP_RISE16);

   // Duty value as seen through the alignment bit
   // Writes land at any time; in PWM modes only the latch below feeds the pin compare
   always_comb begin
      if (align) begin
         duty_buffer = {duty_high_q, duty_low_q[7:6]};
      end else begin
         duty_buffer = {duty_high_q[1:0], duty_low_q};
      end
   end

   // Time base runs at the system clock through the timer ticks and phase
   assign time_base = {timer_count_i, timer_phase_i};
   assign cmp_hit = (compare_timer_i == {duty_high_q, duty_low_q});

   // ------------------------------------------------------------------
   // Wishbone slave
   // ------------------------------------------------------------------
   // One wait state: ack follows the request by one edge, and drops after one cycle.
   // Ack drops even if stb stays high, so a held request is taken again every second cycle
   assign wr_stb = cyc_i && stb_i && we_i && !ack_q;
   assign rd_stb = cyc_i && stb_i && !we_i && !ack_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= cyc_i && stb_i && !ack_q;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         control_q <= ccp_pkg::CCP_CONTROL_RESET;
         duty_low_q <= ccp_pkg::CCP_DUTY_RESET;
         duty_high_q <= ccp_pkg::CCP_DUTY_RESET;
         period_q <= ccp_pkg::CCP_PERIOD_RESET;
      end else if (wr_stb && sel_i[0]) begin
         // Only the low byte lane carries a register; other lanes are ignored
         unique case (adr_i)
            ccp_pkg::CCP_ADDR_CONTROL: control_q <= dat_i[7:0] & ccp_pkg::CCP_CTL_WRITE_MASK;
            ccp_pkg::CCP_ADDR_DUTY_LOW: duty_low_q <= dat_i[7:0];
            ccp_pkg::CCP_ADDR_DUTY_HIGH: duty_high_q <= dat_i[7:0];
            ccp_pkg::CCP_ADDR_PERIOD: period_q <= dat_i[7:0];
            default: ;
         endcase
      end
   end

   // Unmapped addresses read as zero and writes to them are dropped
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_q <= 32'h00000000;
      end else if (rd_stb) begin
         unique case (adr_i)
            ccp_pkg::CCP_ADDR_CONTROL: begin
               rdata_q <= {24'h000000, control_q[7:6], out_q, control_q[4:0]};
            end
            ccp_pkg::CCP_ADDR_DUTY_LOW: rdata_q <= {24'h000000, duty_low_q};
            ccp_pkg::CCP_ADDR_DUTY_HIGH: rdata_q <= {24'h000000, duty_high_q};
            ccp_pkg::CCP_ADDR_PERIOD: rdata_q <= {24'h000000, period_q};
            ccp_pkg::CCP_ADDR_CAPTURE_STATUS: rdata_q <= {15'h0000, capture_seen_q, capture_q};
            default: rdata_q <= 32'h00000000;
         endcase
      end else begin
         rdata_q <= 32'h00000000;
      end
   end

   assign dat_o = rdata_q;
   assign ack_o = ack_q;

   // ------------------------------------------------------------------
   // PWM period and duty
   // ------------------------------------------------------------------
   // Period ends on the increment taken from a count equal to the period
   // register: that same increment wraps the timer, sets the pin and latches
   // the duty. Decoding it at the tick itself keeps the pin edge on the wrap;
   // the clear request tells the shared timer, which may also wrap by itself.
   assign period_end = enable && pwm_mode && timer_tick_i && (timer_count_i == period_q);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         duty_latch_q <= ccp_pkg::CCP_LATCH_RESET;
      end else if (period_end) begin
         duty_latch_q <= duty_buffer;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         timer_clear_o <= 1'b0;
      end else begin
         timer_clear_o <= period_end;
      end
   end

   // ------------------------------------------------------------------
   // Output data bit
   // ------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         out_q <= 1'b0;
         match_q <= 1'b0;
      end else if (!enable) begin
         out_q <= 1'b0;
         match_q <= 1'b0;
      end else if (pwm_mode) begin
         match_q <= 1'b0;
         if (period_end) begin
            // Pin set at period start unless the new duty is zero
            out_q <= (duty_buffer != '0);
         end else if (time_base == duty_latch_q) begin
            out_q <= 1'b0;
         end
         // A duty above the period never matches, so the pin is left as it is
      end else begin
         match_q <= cmp_hit;
         // Capture and off codes leave the data bit as it is
         unique case (mode)
            ccp_pkg::CCP_MODE_CMP_PULSE,
            ccp_pkg::CCP_MODE_CMP_PULSE_CLR: out_q <= cmp_hit;
            // A long match toggles once, at its first cycle only
            ccp_pkg::CCP_MODE_CMP_TOGGLE,
            ccp_pkg::CCP_MODE_CMP_TOGGLE_CLR: begin
               if (cmp_hit && !match_q) begin
                  out_q <= ~out_q;
               end
            end
            ccp_pkg::CCP_MODE_CMP_CLEAR: begin
               if (cmp_hit) begin
                  out_q <= 1'b0;
               end
            end
            ccp_pkg::CCP_MODE_CMP_SET: begin
               if (cmp_hit) begin
                  out_q <= 1'b1;
               end
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         compare_match_o <= 1'b0;
      end else begin
         compare_match_o <= enable && !pwm_mode && !capture_mode && (mode != ccp_pkg::CCP_MODE_OFF)
            && cmp_hit && !match_q;
      end
   end

   // ------------------------------------------------------------------
   // Capture
   // ------------------------------------------------------------------
   // The pin passes two stages; only the second one is read by logic
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cap_sync1_q <= 1'b0;
         cap_sync2_q <= 1'b0;
      end else begin
         cap_sync1_q <= capture_pin_i;
         cap_sync2_q <= cap_sync1_q;
      end
   end

   ccp_edge_div u_edge_div (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .clear_i(!enable || !capture_mode),
      .sig_i(cap_sync2_q),
      .mode_i(mode),
      .event_o(cap_event)
   );

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         capture_q <= 16'h0000;
         capture_seen_q <= 1'b0;
         capture_event_o <= 1'b0;
      end else begin
         capture_event_o <= cap_event && enable && capture_mode;
         // A capture in the same cycle as the clearing write wins
         if (cap_event && enable && capture_mode) begin
            capture_q <= compare_timer_i;
            capture_seen_q <= 1'b1;
         end else if (wr_stb && adr_i == ccp_pkg::CCP_ADDR_CAPTURE_STATUS) begin
            capture_seen_q <= 1'b0;
         end
      end
   end

   assign capture_value_o = capture_q;

   // ------------------------------------------------------------------
   // Output fanout and pin
   // ------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         unit_out_o <= 1'b0;
         pin_oe_o <= 1'b0;
         fanout_o <= '0;
      end else begin
         unit_out_o <= out_q;
         // The pin stays an input while the unit is off, disabled or capturing
         pin_oe_o <= enable && !capture_mode && (mode != ccp_pkg::CCP_MODE_OFF);
         fanout_o.waveform_generator <= out_q;
         fanout_o.adc_trigger <= out_q;
         fanout_o.timer_reset <= out_q;
         fanout_o.signal_measurement_timer <= out_q;
         fanout_o.configurable_logic_cell <= out_q;
         fanout_o.pin_mapping_unit <= out_q;
      end
   end

endmodule

//--- bench/ccp_tb_timer.sv
// Partner model: the shared 8-bit time base with its 2-bit phase, reloading at the period.
// Assumes one clock; the bench hands it the same period value it writes into the block.
module ccp_tb_timer (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] period_i,
   output logic [7:0] count_o,
   output logic [1:0] phase_o,
   output logic tick_o
);
   timeunit 1ns;
   timeprecision 1ps;
   assign tick_o = (phase_o == 2'h3);
   // Phase steps every clock, so the 10-bit time base advances once per system clock
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         phase_o <= 2'h0;
         count_o <= 8'h00;
      end else begin
         phase_o <= phase_o + 2'h1;
         if (tick_o) begin
            count_o <= (count_o == period_i) ? 8'h00 : count_o + 8'h01;
         end
      end
   end
endmodule

//--- bench/ccp_pwm_mode_control_sva.sv
// Checker for the capture/compare/PWM unit, bound to its top module.
// Assumes only the top module's ports are visible.
module ccp_pwm_mode_control_sva #(
   parameter int DUTY_WIDTH = 10
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   input wire logic compare_match_o,
   input wire logic unit_out_o,
   input wire logic pin_oe_o,
   input wire ccp_pkg::ccp_fanout_t fanout_o
);
   ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i) ack_o |=> !ack_o)
      else $error("ack held beyond one cycle");
   ack_wait_a: assert property (@(posedge clk_i) disable iff (rst_i) (cyc_i && stb_i && !ack_o) |=> ack_o)
      else $error("request not answered after one cycle");
   no_spurious_a: assert property (@(posedge clk_i) disable iff (rst_i) !(cyc_i && stb_i) |=> !ack_o)
      else $error("ack without request");
   idle_data_a: assert property (@(posedge clk_i) disable iff (rst_i) !ack_o |-> dat_o == 32'h0)
      else $error("read data not zero while idle");
   high_zero_a: assert property (@(posedge clk_i) disable iff (rst_i) ack_o |-> dat_o[31:17] == 15'h0)
      else $error("unused read bits not zero");
   hole_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (cyc_i && stb_i && !ack_o && !we_i && adr_i == 8'h14) |=> (ack_o && dat_o == 32'h0))
      else $error("unmapped read not zero");
   fanout_copy_a: assert property (@(posedge clk_i) disable iff (rst_i) fanout_o == {6{unit_out_o}})
      else $error("fanout differs from unit output");
   reset_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $fell(rst_i) |-> (!unit_out_o && !pin_oe_o && !ack_o && fanout_o == 6'h00))
      else $error("outputs active after reset");
   match_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i) compare_match_o |=> !compare_match_o)
      else $error("compare match not a single pulse");
endmodule

bind ccp_pwm_mode_control ccp_pwm_mode_control_sva #(.DUTY_WIDTH(DUTY_WIDTH)) i_sva (.clk_i(clk_i), .rst_i(rst_i),
   .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o),
   .compare_match_o(compare_match_o), .unit_out_o(unit_out_o), .pin_oe_o(pin_oe_o), .fanout_o(fanout_o));

//--- bench/tb.sv
// Self-checking bench for the capture/compare/PWM unit.
// Assumes the partner time base model and the bound checker are compiled alongside.
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int P = 63;
   // Two full PWM periods, so any fixed set/clear offset cancels in differences
   localparam int WIN = 8 * (P + 1);
   logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, capture_pin_i, unit_out_o, pin_oe_o, cap_ev, t_clr;
   logic [7:0] adr_i, t_count;
   logic [3:0] sel_i;
   logic [31:0] dat_i, dat_o, rd;
   logic [1:0] t_phase;
   logic t_tick;
   logic [15:0] compare_timer_i, cmp_v, cap_val;
   ccp_pkg::ccp_fanout_t fanout_o;
   int num_errors, num_checks, cycles, cap_cnt, h, h1, d1, clr;
   logic [3:0] cmodes [6] = '{4'h8, 4'h9, 4'h2, 4'h1, 4'hA, 4'hB};
   // Capture modes 3..7: any edge, falling, rising, every 4th, every 16th rise
   int cap_exp [5] = '{32, 16, 16, 4, 1};

   ccp_pwm_mode_control i_ccp_pwm_mode_control (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .timer_count_i(t_count), .timer_tick_i(t_tick), .timer_phase_i(t_phase), .compare_timer_i(compare_timer_i),
      .capture_pin_i(capture_pin_i), .timer_clear_o(t_clr), .compare_match_o(), .capture_event_o(cap_ev),
      .capture_value_o(cap_val), .unit_out_o(unit_out_o), .pin_oe_o(pin_oe_o), .fanout_o(fanout_o));
   ccp_tb_timer i_ccp_tb_timer (.clk_i(clk_i), .rst_i(rst_i), .period_i(8'(P)), .count_o(t_count),
      .phase_o(t_phase), .tick_o(t_tick));

   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   always @(posedge clk_i) begin
      cycles++;
      if (cap_ev === 1'b1) cap_cnt++;
      if (cycles == 20000) begin
         num_errors++;
         give_verdict();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %0t %s: saw %h want %h", $time, what, seen, exp);
      end
   endtask

   // -----------------------------------------------------------------
   // Wishbone classic master
   // -----------------------------------------------------------------
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= {24'h000000, d};
      // Only the bench watchdog ends a wait for ack
      do begin
         @(posedge clk_i);
      end while (ack_o !== 1'b1);
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m, input string what);
      wb(1'b0, a, 8'h00);
      chk(rd & m, exp, what);
   endtask

   // Alignment bit picks where the ten duty bits sit in the register pair
   task automatic pwm(input logic [7:0] ctl, input int d);
      wb(1'b1, ccp_pkg::CCP_ADDR_CONTROL, ctl);
      wb(1'b1, ccp_pkg::CCP_ADDR_DUTY_HIGH, ctl[4] ? 8'(d >> 2) : 8'(d >> 8));
      wb(1'b1, ccp_pkg::CCP_ADDR_DUTY_LOW, ctl[4] ? 8'((d & 3) << 6) : 8'(d));
      repeat (WIN) @(posedge clk_i);
      h = 0;
      clr = 0;
      repeat (WIN) begin
         @(posedge clk_i);
         if (unit_out_o === 1'b1) h++;
         if (t_clr === 1'b1) clr++;
      end
   endtask

   task automatic give_verdict();
      if (num_errors == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   initial begin
      rst_i = 1'b1;
      cyc_i = 1'b0;
      stb_i = 1'b0;
      we_i = 1'b0;
      adr_i = 8'h00;
      sel_i = 4'hF;
      dat_i = 32'h0;
      capture_pin_i = 1'b0;
      compare_timer_i = 16'h0000;
      void'($urandom(90624));
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 6; i++) rchk(8'(4 * i), (i == 3) ? 32'hFF : 32'h0, 32'hFFFFFFFF, "reset");
      wb(1'b1, 8'h14, 8'hFF);
      rchk(8'h14, 32'h0, 32'hFFFFFFFF, "hole");
      wb(1'b1, ccp_pkg::CCP_ADDR_CONTROL, 8'hDC);
      rchk(ccp_pkg::CCP_ADDR_CONTROL, 32'h9C, 32'hFFFFFFDF, "control");
      wb(1'b1, ccp_pkg::CCP_ADDR_PERIOD, 8'(P));
      d1 = 20 + ($urandom % 100);
      pwm(8'h8C, d1);
      h1 = h;
      chk(clr, 2, "period wraps");
      pwm(8'h9D, d1 + 90);
      chk(h - h1, 2 * 90, "pulse width");
      chk(pin_oe_o, 1'b1, "drive on");
      pwm(8'h8F, 0);
      chk(h, 0, "zero duty");
      pwm(8'h8C, 1000);
      chk(h, WIN, "duty above period");
      pwm(8'h0C, 1000);
      chk(h, 0, "disabled out");
      chk(pin_oe_o, 1'b0, "disabled drive");
      chk(clr, 0, "disabled wraps");
      wb(1'b1, ccp_pkg::CCP_ADDR_CONTROL, 8'h8C);
      repeat (WIN) @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk({unit_out_o, pin_oe_o}, 2'b00, "reset outputs");
      rchk(ccp_pkg::CCP_ADDR_PERIOD, 32'hFF, 32'hFFFFFFFF, "period reset");
      rchk(ccp_pkg::CCP_ADDR_DUTY_LOW, 32'h0, 32'hFFFFFFFF, "duty reset");
      cmp_v = 16'($urandom);
      compare_timer_i <= ~cmp_v;
      wb(1'b1, ccp_pkg::CCP_ADDR_DUTY_LOW, cmp_v[7:0]);
      wb(1'b1, ccp_pkg::CCP_ADDR_DUTY_HIGH, cmp_v[15:8]);
      for (int i = 0; i < 6; i++) begin
         wb(1'b1, ccp_pkg::CCP_ADDR_CONTROL, {4'h8, cmodes[i]});
         compare_timer_i <= cmp_v;
         repeat (6) @(posedge clk_i);
         if (i >= 4) chk(unit_out_o, 1'b1, "pulse while equal");
         compare_timer_i <= ~cmp_v;
         repeat (6) @(posedge clk_i);
         chk(unit_out_o, (i % 2 == 0 && i < 4) ? 1'b1 : 1'b0, "compare out");
      end
      for (int i = 0; i < 5; i++) begin
         wb(1'b1, ccp_pkg::CCP_ADDR_CONTROL, 8'h80);
         wb(1'b1, ccp_pkg::CCP_ADDR_CONTROL, 8'h83 + 8'(i));
         cap_cnt = 0;
         repeat (16) begin
            capture_pin_i <= 1'b1;
            repeat (4) @(posedge clk_i);
            capture_pin_i <= 1'b0;
            repeat (4) @(posedge clk_i);
         end
         repeat (6) @(posedge clk_i);
         chk(cap_cnt, cap_exp[i], "capture count");
         chk(cap_val, {16'h0000, ~cmp_v}, "capture value");
      end
      rchk(ccp_pkg::CCP_ADDR_CAPTURE_STATUS, {15'h0000, 1'b1, ~cmp_v}, 32'hFFFFFFFF, "capture status");
      give_verdict();
   end
endmodule
